// ==== logic/art5_pkg.sv ====
// Package: register map, field layout and constants for the reload timer
// Summary of operation
// [R01] Count is two software-accessible 8-bit bytes
// [R02] 16-bit wrap reloads count, sets high flag
// [R03] 16-bit overflow requests interrupt when enabled
// [R04] Low-byte wrap also interrupts when low-enable set
// [R05] Split mode: two 8-bit auto-reload timers
// [R06] Split: run bit gates only high byte
// [R07] Per-half clock: system_clock, system_clock/12, ext/8
// [R08] External divided clock synchronised before use
// [R09] High and low wrap flags set by hardware
// [R10] Split: either byte overflow may interrupt
// [R11] Flags cleared only by software writes
// [R12] Software reads both flags to find source
// [R13] Control bits 4 and 1 read zero
// [R14] 16-bit mode: run bit starts and stops
// [R15] Control bit layout, all reset zero
// [R16] 16-bit mode uses low-half clock, carry chains
package art5_pkg;
	localparam logic [7:0] ART5_CONTROL_OFS = 8'hc8;
	localparam logic [7:0] ART5_RELOAD_LO_OFS = 8'hca;
	localparam logic [7:0] ART5_RELOAD_HI_OFS = 8'hcb;
	localparam logic [7:0] ART5_COUNT_LO_OFS = 8'hcc;
	localparam logic [7:0] ART5_COUNT_HI_OFS = 8'hcd;
	// Chosen offsets for clock selects, irq enable, status and mask
	localparam logic [7:0] ART5_CLKCTL_OFS = 8'hd0;
	localparam logic [7:0] ART5_IRQEN_OFS = 8'hd4;
	localparam logic [7:0] ART5_STATUS_OFS = 8'hd8;
	localparam logic [7:0] ART5_MASK_OFS = 8'hdc;
	localparam int ART5_HF_BIT = 7;
	localparam int ART5_LF_BIT = 6;
	localparam int ART5_LEN_BIT = 5;
	localparam int ART5_SPLIT_BIT = 3;
	localparam int ART5_RUN_BIT = 2;
	localparam int ART5_XCLK_BIT = 0;
	localparam logic [7:0] ART5_CTL_WMASK = 8'hed;
	localparam logic [7:0] ART5_CTL_RESET = 8'h00;
	localparam logic [7:0] ART5_BYTE_MAX = 8'hff;
	localparam int ART5_CLKCTL_LO_BIT = 0;
	localparam int ART5_CLKCTL_HI_BIT = 1;
	localparam int ART5_SYS_DIV = 12;
	localparam int ART5_EXT_DIV = 8;
	localparam logic [1:0] ART5_HTRANS_NONSEQ = 2'h2;
	typedef enum logic [1:0] {
		ART5_TICK_DIV12 = 2'h0,
		ART5_TICK_EXT = 2'h1,
		ART5_TICK_SYS = 2'h3
	} art5_tick_t;
endpackage

// ==== logic/art5_sync.sv ====
// Two-flop synchroniser with edge pulse on the second-stage output
`timescale 1ns/1ps
module art5_sync (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic async_in,
	output logic      rise_pulse
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	// Edge taken from the second stage only
	assign rise_pulse = sync_q & ~last_q;
endmodule // art5_sync

// ==== logic/art5_half.sv ====
// One 8-bit auto-reload counter half with wrap pulse
`timescale 1ns/1ps
module art5_half
	import art5_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             tick,
	input  wire logic             wr_en,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [WIDTH-1:0] reload,
	output logic      [WIDTH-1:0] count_q,
	output logic                  wrap
);
	logic [WIDTH-1:0] count_d;

	assign wrap = tick & (count_q == {WIDTH{1'b1}});
	// Software write wins over a same-cycle count step
	assign count_d = wr_en ? wr_data :
		wrap ? reload :
		tick ? count_q + {{(WIDTH-1){1'b0}}, 1'b1} : count_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			count_q <= '0;
		else
			count_q <= count_d;
	end
endmodule // art5_half

// ==== logic/art5_timer.sv ====
// Reload timer top: AHB-Lite slave, clock selection, counters, irq
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
module art5_timer
	import art5_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        ext_osc,
	output logic             timer_irq,
	output logic             irq
);
	////////////////////////////////////////////////////////////////////
	logic [7:0] ctl_q;
	logic [7:0] rl_lo_q;
	logic [7:0] rl_hi_q;
	logic [1:0] clkctl_q;
	logic       irqen_q;
	logic [1:0] sts_q;
	logic [1:0] mask_q;
	logic [7:0] addr_q;
	logic       wr_q;
	logic       rd_q;
	logic [31:0] rdata_q;
	logic [3:0] div12_q;
	logic [1:0] ext_div_q;
	logic       ext_clk_q;

	////////////////////////////////////////////////////////////////////
	// Bus address phase capture; always zero wait states
	wire bus_go = hsel & hready & (htrans == ART5_HTRANS_NONSEQ);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	wire wr_ctl = wr_q & hit(addr_q, ART5_CONTROL_OFS);
	wire wr_rll = wr_q & hit(addr_q, ART5_RELOAD_LO_OFS);
	wire wr_rlh = wr_q & hit(addr_q, ART5_RELOAD_HI_OFS);
	wire wr_cl = wr_q & hit(addr_q, ART5_COUNT_LO_OFS);
	wire wr_ch = wr_q & hit(addr_q, ART5_COUNT_HI_OFS);
	wire wr_cc = wr_q & hit(addr_q, ART5_CLKCTL_OFS);
	wire wr_ie = wr_q & hit(addr_q, ART5_IRQEN_OFS);
	wire wr_st = wr_q & hit(addr_q, ART5_STATUS_OFS);
	wire wr_mk = wr_q & hit(addr_q, ART5_MASK_OFS);
	wire [7:0] wb = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 8'h00;
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
		end else begin
			addr_q <= haddr[7:0];
			wr_q   <= bus_go & hwrite;
			rd_q   <= bus_go & ~hwrite;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Count clock sources
	wire div12_end = (div12_q == 4'(ART5_SYS_DIV - 1));
	wire ext_raw = ext_clk_q;
	wire ext_tick;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			div12_q <= 4'h0;
		else
			div12_q <= div12_end ? 4'h0 : div12_q + 4'h1;
	end

	// Divide external oscillator by 8 in its own flops
	always_ff @(posedge ext_osc or negedge hresetn) begin
		if (!hresetn) begin
			ext_div_q <= 2'h0;
			ext_clk_q <= 1'b0;
		end else begin
			ext_div_q <= ext_div_q + 2'h1;
			if (ext_div_q == 2'(ART5_EXT_DIV / 2 - 1))
				ext_clk_q <= ~ext_clk_q;
		end
	end

	art5_sync u_sync ( // R08
		.hclk      (hclk),
		.hresetn   (hresetn),
		.async_in  (ext_raw),
		.rise_pulse(ext_tick)
	);

	function automatic logic pick_tick(input logic sel, input logic xclk,
			input logic d12, input logic ext);
		art5_tick_t k;
		k = art5_tick_t'({sel, sel | xclk});
		case (k)
			ART5_TICK_SYS:   return 1'b1;
			ART5_TICK_EXT:   return ext;
			default:         return d12;
		endcase
	endfunction

	wire split = ctl_q[ART5_SPLIT_BIT];
	wire run = ctl_q[ART5_RUN_BIT];
	wire xclk = ctl_q[ART5_XCLK_BIT];
	wire lo_src = pick_tick(clkctl_q[ART5_CLKCTL_LO_BIT], xclk, // R07
		div12_end, ext_tick);
	wire hi_src = pick_tick(clkctl_q[ART5_CLKCTL_HI_BIT], xclk, // R07
		div12_end, ext_tick);

	////////////////////////////////////////////////////////////////////
	// Counter halves
	logic [7:0] cnt_lo;
	logic [7:0] cnt_hi;
	logic       lo_wrap;
	logic       hi_wrap;
	wire lo_tick = split ? lo_src : (run & lo_src); // R06 R14 R16
	wire hi_tick = split ? (run & hi_src) : // R06
		(run & lo_src & (cnt_lo == ART5_BYTE_MAX)); // R16
	// 16-bit mode reloads the low byte only on the full wrap
	wire [7:0] lo_reload = (split | (cnt_hi == ART5_BYTE_MAX)) ?
		rl_lo_q : 8'h00; // R02 R05

	art5_half #(.WIDTH(8)) u_lo ( // R01
		.hclk   (hclk),
		.hresetn(hresetn),
		.tick   (lo_tick),
		.wr_en  (wr_cl),
		.wr_data(wb),
		.reload (lo_reload),
		.count_q(cnt_lo),
		.wrap   (lo_wrap)
	);

	art5_half #(.WIDTH(8)) u_hi ( // R01
		.hclk   (hclk),
		.hresetn(hresetn),
		.tick   (hi_tick),
		.wr_en  (wr_ch),
		.wr_data(wb),
		.reload (rl_hi_q),
		.count_q(cnt_hi),
		.wrap   (hi_wrap)
	);

	////////////////////////////////////////////////////////////////////
	// Control register; hardware set beats software clear
	wire [7:0] ctl_w = wr_ctl ? ((wb & ART5_CTL_WMASK) | // R13 R15
		(ctl_q & ~ART5_CTL_WMASK)) : ctl_q;
	logic [7:0] ctl_d;
	always_comb begin
		ctl_d = ctl_w;
		if (hi_wrap)
			ctl_d[ART5_HF_BIT] = 1'b1; // R02 R09 R11
		if (lo_wrap)
			ctl_d[ART5_LF_BIT] = 1'b1; // R09 R11
	end

	wire [1:0] evt = {hi_wrap, lo_wrap};
	wire [1:0] sts_d = (sts_q & ~(wr_st ? wb[1:0] : 2'b00)) | evt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_q    <= ART5_CTL_RESET;
			rl_lo_q  <= 8'h00;
			rl_hi_q  <= 8'h00;
			clkctl_q <= 2'h0;
			irqen_q  <= 1'b0;
			sts_q    <= 2'h0;
			mask_q   <= 2'h0;
		end else begin
			ctl_q   <= ctl_d;
			sts_q   <= sts_d;
			if (wr_rll)
				rl_lo_q <= wb;
			if (wr_rlh)
				rl_hi_q <= wb;
			if (wr_cc)
				clkctl_q <= wb[1:0];
			if (wr_ie)
				irqen_q <= wb[0];
			if (wr_mk)
				mask_q <= wb[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Timer interrupt follows the flags; low flag needs its enable
	assign timer_irq = irqen_q & (ctl_q[ART5_HF_BIT] | // R03 R10
		(ctl_q[ART5_LEN_BIT] & ctl_q[ART5_LF_BIT])); // R04 R10
	assign irq = |(sts_q & mask_q);

	////////////////////////////////////////////////////////////////////
	// Read data registered in the data phase
	wire [7:0] ra = haddr[7:0];
	wire [7:0] rsel =
		hit(ra, ART5_CONTROL_OFS)   ? ctl_q :
		hit(ra, ART5_RELOAD_LO_OFS) ? rl_lo_q :
		hit(ra, ART5_RELOAD_HI_OFS) ? rl_hi_q :
		hit(ra, ART5_COUNT_LO_OFS)  ? cnt_lo : // R01
		hit(ra, ART5_COUNT_HI_OFS)  ? cnt_hi :
		hit(ra, ART5_CLKCTL_OFS)    ? {6'h00, clkctl_q} :
		hit(ra, ART5_IRQEN_OFS)     ? {7'h00, irqen_q} :
		hit(ra, ART5_STATUS_OFS)    ? {6'h00, sts_q} :
		hit(ra, ART5_MASK_OFS)      ? {6'h00, mask_q} : 8'h00;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rdata_q <= 32'h0000_0000;
		else if (bus_go & ~hwrite)
			rdata_q <= {24'h000000, rsel};
	end
	assign hrdata = rdata_q;

	////////////////////////////////////////////////////////////////////
	// Checks
	sequence full_wrap_s;
		!split && hi_wrap;
	endsequence

	flag_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R11
		$past(ctl_q[ART5_HF_BIT]) && !$past(wr_ctl) |-> ctl_q[ART5_HF_BIT])
		else $error("high flag dropped without write");
	hi_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // R09
		hi_wrap |=> ctl_q[ART5_HF_BIT])
		else $error("high flag not set on wrap");
	lo_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // R09
		lo_wrap |=> ctl_q[ART5_LF_BIT])
		else $error("low flag not set on wrap");
	full_reload_a: assert property (@(posedge hclk) disable iff (!hresetn) // R02
		full_wrap_s and !wr_ch and !wr_cl |=>
		cnt_hi == $past(rl_hi_q) && cnt_lo == $past(rl_lo_q))
		else $error("16-bit reload wrong");
	split_lo_run_a: assert property (@(posedge hclk) disable iff (!hresetn) // R06
		split && lo_src && !wr_cl |=> cnt_lo == ($past(lo_wrap) ?
		$past(rl_lo_q) : $past(cnt_lo) + 8'h01))
		else $error("low half stalled in split");
	stop_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R14
		!run && !wr_ch && !wr_cl && !split |=>
		cnt_hi == $past(cnt_hi) && cnt_lo == $past(cnt_lo))
		else $error("counter moved while stopped");
	unused_zero_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
		ctl_q[4] == 1'b0 && ctl_q[1] == 1'b0)
		else $error("unused control bit set");
	irq_hi_a: assert property (@(posedge hclk) disable iff (!hresetn) // R03
		irqen_q && hi_wrap && !wr_ie |=> timer_irq)
		else $error("timer irq missing on overflow");
	div12_a: assert property (@(posedge hclk) disable iff (!hresetn) // R07
		div12_end |=> !div12_end [*8] ##1 !div12_end [*3] ##1
		div12_end)
		else $error("divide by 12 period wrong");
endmodule // art5_timer

// ==== test/art5_timer_tb_top.sv ====
// Self-checking bench for the reload timer over AHB-Lite
`timescale 1ns/1ps
module art5_timer_tb_top;
	import art5_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hready, ext_osc, ext_en;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, timer_irq, irq;
	logic [7:0]  v, a;
	int          err_total, cmp_count, i;
	typedef struct {logic [7:0] adr; logic [7:0] wd; logic [7:0] ex;} row_t;
	row_t rows[13];
	////////////////////////////////////////////////////////////////////////
	art5_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ext_osc(ext_osc),
		.timer_irq(timer_irq), .irq(irq));
	// Single slave: its ready is the bus ready
	assign hready = hreadyout;
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	// Free-running oscillator stand-in, one toggle per 4 hclk
	always @(posedge hclk) begin
		if (ext_en && $time % 200 == 25)
			ext_osc <= ~ext_osc;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic bus(input logic w, input logic [7:0] ad,
		input logic [7:0] d, output logic [7:0] r);
		hsel <= 1'b1;
		haddr <= {24'h000000, ad};
		hwrite <= w;
		htrans <= ART5_HTRANS_NONSEQ;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h000000, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata[7:0];
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		logic [7:0] r;
		bus(1'b1, ad, d, r);
	endtask
	task automatic chk(input string nm, input logic [7:0] ex,
		input logic [7:0] got);
		cmp_count++;
		if (got !== ex) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic rdchk(input logic [7:0] ad, input logic [7:0] ex);
		bus(1'b0, ad, 8'h00, v);
		chk("register", ex, v);
		chk("hresp", 8'h00, {7'h00, hresp});
	endtask
	task automatic irqchk(input logic ti, input logic ir);
		@(negedge hclk);
		chk("timer_irq", {7'h00, ti}, {7'h00, timer_irq});
		chk("irq", {7'h00, ir}, {7'h00, irq});
		@(posedge hclk);
	endtask
	// Tick count over a window, one step of slack for phase
	task automatic rate(input int n, input logic [7:0] ex);
		bus(1'b0, ART5_COUNT_LO_OFS, 8'h00, a);
		repeat (n) @(posedge hclk);
		bus(1'b0, ART5_COUNT_LO_OFS, 8'h00, v);
		v = v - a;
		chk("rate", 8'h00, (v + 8'h01 - ex) > 8'h02 ? v : 8'h00);
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#(50 * 12000);
		err_total++;
		final_report;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		{hsel, hwrite, ext_osc, ext_en, htrans, hsize} = '0;
		{haddr, hwdata} = '0;
		hsize = 3'h2;
		hresetn = 1'b0;
		err_total = 0;
		cmp_count = 0;
		rows = '{'{ART5_RELOAD_LO_OFS, 8'ha5, 8'ha5},
			'{ART5_RELOAD_HI_OFS, 8'h5a, 8'h5a},
			'{ART5_COUNT_HI_OFS, 8'h3c, 8'h3c},
			'{ART5_COUNT_LO_OFS, 8'hc3, 8'hc3},
			'{ART5_CONTROL_OFS, 8'hff, 8'hed},
			'{ART5_CONTROL_OFS, 8'h00, 8'h00},
			'{ART5_IRQEN_OFS, 8'h01, 8'h01},
			'{ART5_MASK_OFS, 8'h03, 8'h03},
			'{ART5_MASK_OFS, 8'h00, 8'h00},
			'{ART5_CLKCTL_OFS, 8'h03, 8'h03},
			'{ART5_CLKCTL_OFS, 8'h00, 8'h00},
			'{8'he0, 8'hff, 8'h00},
			'{ART5_STATUS_OFS, 8'h00, 8'h00}};
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (i = 0; i < 5; i++)
			rdchk(ART5_CONTROL_OFS + i[7:0], 8'h00);
		irqchk(1'b0, 1'b0);
		for (i = 0; i < 13; i++) begin
			wr(rows[i].adr, rows[i].wd);
			rdchk(rows[i].adr, rows[i].ex);
		end
		// 16-bit wrap: 0xfff0 reaches 0xffff 15 system_clock later
		wr(ART5_RELOAD_LO_OFS, 8'h34);
		wr(ART5_RELOAD_HI_OFS, 8'h12);
		wr(ART5_COUNT_LO_OFS, 8'hf0);
		wr(ART5_COUNT_HI_OFS, 8'hff);
		wr(ART5_CLKCTL_OFS, 8'h01);
		wr(ART5_CONTROL_OFS, 8'h04);
		repeat (20) @(posedge hclk);
		rdchk(ART5_COUNT_HI_OFS, 8'h12);
		rdchk(ART5_CONTROL_OFS, 8'hc4);
		irqchk(1'b1, 1'b0);
		wr(ART5_CONTROL_OFS, 8'h40);
		irqchk(1'b0, 1'b0);
		wr(ART5_CONTROL_OFS, 8'h60);
		irqchk(1'b1, 1'b0);
		bus(1'b0, ART5_COUNT_LO_OFS, 8'h00, a);
		repeat (10) @(posedge hclk);
		rdchk(ART5_COUNT_LO_OFS, a);
		rdchk(ART5_CONTROL_OFS, 8'h60);
		// Status, mask and the combined line
		rdchk(ART5_STATUS_OFS, 8'h03);
		wr(ART5_MASK_OFS, 8'h01);
		irqchk(1'b1, 1'b1);
		wr(ART5_STATUS_OFS, 8'h01);
		irqchk(1'b1, 1'b0);
		rdchk(ART5_STATUS_OFS, 8'h02);
		wr(ART5_MASK_OFS, 8'h02);
		irqchk(1'b1, 1'b1);
		wr(ART5_STATUS_OFS, 8'h02);
		irqchk(1'b1, 1'b0);
		// Split: low byte free-runs, high byte held by run bit
		wr(ART5_CONTROL_OFS, 8'h08);
		wr(ART5_CLKCTL_OFS, 8'h03);
		wr(ART5_RELOAD_LO_OFS, 8'ha0);
		wr(ART5_RELOAD_HI_OFS, 8'h00);
		wr(ART5_COUNT_HI_OFS, 8'hfc);
		wr(ART5_COUNT_LO_OFS, 8'hf8);
		repeat (20) @(posedge hclk);
		rdchk(ART5_COUNT_HI_OFS, 8'hfc);
		rdchk(ART5_CONTROL_OFS, 8'h48);
		bus(1'b0, ART5_COUNT_LO_OFS, 8'h00, v);
		chk("split low", 8'h01, {7'h00, v >= 8'ha0 && v < 8'hc0});
		wr(ART5_CONTROL_OFS, 8'h0c);
		repeat (20) @(posedge hclk);
		// Run write cleared the low flag; low byte has not wrapped since
		rdchk(ART5_CONTROL_OFS, 8'h8c);
		bus(1'b0, ART5_COUNT_HI_OFS, 8'h00, v);
		chk("split high", 8'h01, {7'h00, v < 8'h20});
		// High wrap left its status bit set under the high mask
		wr(ART5_CONTROL_OFS, 8'h08);
		irqchk(1'b0, 1'b1);
		wr(ART5_CONTROL_OFS, 8'h48);
		irqchk(1'b0, 1'b1);
		wr(ART5_CONTROL_OFS, 8'h68);
		irqchk(1'b1, 1'b1);
		// Clock sources in 16-bit mode
		wr(ART5_CLKCTL_OFS, 8'h00);
		wr(ART5_CONTROL_OFS, 8'h04);
		rate(120, 8'h0a);
		ext_en <= 1'b1;
		wr(ART5_CONTROL_OFS, 8'h05);
		rate(640, 8'h0a);
		// Reset in mid-run clears control, low count and both lines
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk(ART5_CONTROL_OFS, ART5_CTL_RESET);
		rdchk(ART5_COUNT_LO_OFS, 8'h00);
		irqchk(1'b0, 1'b0);
		final_report;
	end
endmodule // art5_timer_tb_top
